/* File: verilog/hkgate_pkg.sv */
`default_nettype none
package hkgate_pkg;
   // Primary header constants of an accepted command
   localparam logic [2:0]  VERSION_NUMBER   = 3'h0;
   localparam logic        TYPE_TC          = 1'h1;
   localparam logic        DFH_FLAG         = 1'h1;
   localparam logic [6:0]  APID_VALUE       = 7'h47;
   localparam logic [3:0]  CATEGORY_VALUE   = 4'hc;
   localparam logic [1:0]  SEQ_FLAGS_VALUE  = 2'h3;
   localparam logic [2:0]  SEQ_SOURCE_GND   = 3'h0;
   localparam logic [15:0] LENGTH_VALUE     = 16'h0007;
   // Secondary header constants
   localparam logic [2:0]  SEC_VERSION      = 3'h0;
   localparam logic        CKSUM_FLAG       = 1'h1;
   localparam logic [3:0]  ACK_VALUE        = 4'h1;
   localparam logic [7:0]  SERVICE_HK       = 8'h03;
   localparam logic [7:0]  SUBTYPE_ENABLE   = 8'h05;
   localparam logic [7:0]  SUBTYPE_DISABLE  = 8'h06;
   localparam logic [7:0]  PAD_HEADER       = 8'h00;
   // Application data
   localparam logic [7:0]  PAD_PARAM_VALUE  = 8'h01;
   localparam logic [7:0]  SELECTOR_VALUE   = 8'h01;
   // Packet size in bytes: 6 primary, 4 secondary, 2 data, 2 checksum
   localparam int          PACKET_BYTES     = 14;
   // Forwarding state after reset
   localparam logic        FWD_RESET        = 1'h0;
   // Housekeeping cycle period
   localparam int          CLOCK_HZ         = 40000000;
   localparam int          HK_PERIOD_MS     = 11300;
   localparam longint      HK_PERIOD_CYC    = longint'(HK_PERIOD_MS) * CLOCK_HZ / 1000;
endpackage
`default_nettype wire

/* File: verilog/hkgate_cksum.sv */
`timescale 1ns/1ps
`default_nettype none
// Running 16-bit packet checksum over the command bytes
module hkgate_cksum
   import hkgate_pkg::*;
(
   // Clock and control
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        clk_en,
   // Byte stream
   input  wire logic        clear,
   input  wire logic        take,
   input  wire logic [7:0]  data,
   // Running sum
   output logic [15:0]      sum
);
   // Even bytes feed the high half, odd bytes the low half
   logic                    odd;  // Byte position parity

   // Word-wise XOR accumulation
   always_ff @(posedge clock) begin
      if (srst || (clk_en && clear)) begin
         sum <= 16'h0000;
         odd <= 1'b0;
      end else if (clk_en && take) begin
         if (odd) begin
            sum[7:0] <= sum[7:0] ^ data;
         end else begin
            sum[15:8] <= sum[15:8] ^ data;
         end
         odd <= ~odd;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/hkgate_top.sv */
`timescale 1ns/1ps
`default_nettype none
module hkgate_top
   import hkgate_pkg::*;
#(
   parameter longint PERIOD_CYC = HK_PERIOD_CYC
)(
   // Clock and control
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        clk_en,
   // Telecommand byte stream
   input  wire logic        tc_valid,
   input  wire logic [7:0]  tc_data,
   input  wire logic        tc_last,
   output logic             tc_ready,
   // Cycle skip from engineering command path
   input  wire logic        cycle_skip,
   // Packet completion from the packetizer
   input  wire logic        hk_done,
   // Outputs
   output logic             cycle_start,
   output logic             hk_forward,
   output logic             hk_discard,
   output logic             fwd_enabled,
   output logic             cmd_accepted,
   output logic             cmd_rejected
);
   typedef enum {st_recv, st_drain} hkgate_state_type;

   hkgate_state_type        state;      // Receiver state
   logic [3:0]              index;      // Byte index in packet
   logic [7:0]              hdr [0:11]; // Captured header and data bytes
   logic [15:0]             sum;        // Running checksum
   logic [15:0]             sum_held;   // Sum over bytes before checksum
   logic [7:0]              ck_hi;      // First checksum byte
   logic                    take;       // Byte accepted this cycle
   logic                    good_hdr;   // Header and data match
   logic                    finish;     // Last byte of a full packet
   logic [39:0]             cyc_cnt;    // Cycle period counter

   // Always ready; no backlog to stall on
   assign tc_ready = 1'b1;
   assign take     = clk_en && tc_valid;
   assign finish   = take && (index == 4'(PACKET_BYTES - 1));

   // Header comparison against fixed command layout
   function automatic logic hdr_ok(input logic [7:0] b [0:11]);
      hdr_ok = (b[0] == {VERSION_NUMBER, TYPE_TC, DFH_FLAG, APID_VALUE[6:4]})
            && (b[1] == {APID_VALUE[3:0], CATEGORY_VALUE})
            && (b[2][7:6] == SEQ_FLAGS_VALUE) && (b[2][5:3] == SEQ_SOURCE_GND)
            && ({b[4], b[5]} == LENGTH_VALUE)
            // Only the acceptance-acknowledge form passes; other codes refused
            && (b[6] == {SEC_VERSION, CKSUM_FLAG, ACK_VALUE})
            && (b[7] == SERVICE_HK)
            && (b[9] == PAD_HEADER)
            && (b[10] == PAD_PARAM_VALUE) && (b[11] == SELECTOR_VALUE);
   endfunction

   // Sequence count is not checked: the sender owns it
   assign good_hdr = hdr_ok(hdr);

   hkgate_cksum u_cksum (
      .clock  (clock),
      .srst   (srst),
      .clk_en (clk_en),
      .clear  (finish || (take && tc_last)),
      .take   (take && index < 4'(PACKET_BYTES - 2)),
      .data   (tc_data),
      .sum    (sum)
   );

   // Byte capture and framing
   always_ff @(posedge clock) begin
      if (srst) begin
         state    <= st_recv;
         index    <= 4'h0;
         ck_hi    <= 8'h00;
         sum_held <= 16'h0000;
      end else if (take) begin
         case (state)
            st_recv: begin
               if (tc_last || index == 4'(PACKET_BYTES - 1)) begin
                  index <= 4'h0;
                  // Full length without a last marker: skip the tail
                  state <= tc_last ? st_recv : st_drain;
               end else begin
                  index <= index + 4'h1;
               end
               if (index < 4'(PACKET_BYTES - 2)) begin
                  hdr[index] <= tc_data;
               end
               if (index == 4'(PACKET_BYTES - 2)) begin
                  ck_hi    <= tc_data;
                  sum_held <= sum;
               end
            end
            st_drain: begin
               // Overlong packet: skip until its last byte
               if (tc_last) begin
                  state <= st_recv;
               end
            end
            default: state <= st_recv;
         endcase
      end
   end

   // Command decision and forwarding state
   always_ff @(posedge clock) begin
      if (srst) begin
         fwd_enabled  <= FWD_RESET;
         cmd_accepted <= 1'b0;
         cmd_rejected <= 1'b0;
      end else if (clk_en) begin
         cmd_accepted <= 1'b0;
         cmd_rejected <= 1'b0;
         // Last marker before byte 14: short packet
         if (state == st_recv && take && tc_last && !finish) begin
            cmd_rejected <= 1'b1;
         end else if (finish) begin
            if (good_hdr && {ck_hi, tc_data} == sum_held &&
                (hdr[8] == SUBTYPE_ENABLE || hdr[8] == SUBTYPE_DISABLE)) begin
               cmd_accepted <= 1'b1;
               fwd_enabled  <= (hdr[8] == SUBTYPE_ENABLE);
            end else begin
               cmd_rejected <= 1'b1;
            end
         end
      end
   end

   // Free-running cycle timer, independent of forwarding
   always_ff @(posedge clock) begin
      if (srst) begin
         cyc_cnt     <= 40'h0;
         cycle_start <= 1'b0;
      end else if (clk_en) begin
         cycle_start <= 1'b0;
         if (cyc_cnt == 40'(PERIOD_CYC - 1)) begin
            cyc_cnt     <= 40'h0;
            cycle_start <= !cycle_skip;
         end else begin
            cyc_cnt <= cyc_cnt + 40'h1;
         end
      end
   end

   // Gate completed packets; collection is untouched
   always_ff @(posedge clock) begin
      if (srst) begin
         hk_forward <= 1'b0;
         hk_discard <= 1'b0;
      end else if (clk_en) begin
         hk_forward <= hk_done && fwd_enabled;
         hk_discard <= hk_done && !fwd_enabled;
      end
   end

   // Gate outputs
   a_gate_excl: assert property (@(posedge clock) disable iff (srst)
      !(hk_forward && hk_discard))
      else $error("forward and discard both high");
   a_fwd_follow: assert property (@(posedge clock) disable iff (srst)
      clk_en && hk_done |=> hk_forward == $past(fwd_enabled))
      else $error("forward does not follow enable");
   a_drop_disabled: assert property (@(posedge clock) disable iff (srst)
      clk_en && hk_done && !fwd_enabled |=> hk_discard && !hk_forward)
      else $error("completed packet not dropped");
   // Command results and forwarding state
   a_reject_hold: assert property (@(posedge clock) disable iff (srst)
      cmd_rejected |-> $stable(fwd_enabled))
      else $error("rejected command changed state");
   a_enable_set: assert property (@(posedge clock) disable iff (srst)
      cmd_accepted && $rose(fwd_enabled) |-> $past(hdr[8]) == SUBTYPE_ENABLE)
      else $error("enable without subtype five");
   a_disable_clr: assert property (@(posedge clock) disable iff (srst)
      cmd_accepted && $past(hdr[8]) == SUBTYPE_DISABLE |-> !fwd_enabled)
      else $error("disable did not clear");
   a_change_cause: assert property (@(posedge clock) disable iff (srst)
      !$stable(fwd_enabled) && !$past(srst) |-> cmd_accepted)
      else $error("state changed without command");
   a_one_result: assert property (@(posedge clock) disable iff (srst)
      !(cmd_accepted && cmd_rejected))
      else $error("accept and reject together");
   a_reset_off: assert property (@(posedge clock) disable iff (srst)
      $past(srst) |-> fwd_enabled == FWD_RESET)
      else $error("forwarding not at reset default");
   // Framing: short, bad and overlong packets
   a_short_reject: assert property (@(posedge clock) disable iff (srst)
      take && tc_last && state == st_recv && !finish |=> cmd_rejected)
      else $error("short packet not rejected");
   a_header_reject: assert property (@(posedge clock) disable iff (srst)
      finish && !good_hdr |=> cmd_rejected)
      else $error("bad header not rejected");
   a_drain_quiet: assert property (@(posedge clock) disable iff (srst)
      take && state == st_drain |=> !cmd_accepted && !cmd_rejected)
      else $error("skipped tail gave a result");
   // Collection cycle timer
   a_cycle_pulse: assert property (@(posedge clock) disable iff (srst)
      clk_en && cycle_start |=> !cycle_start)
      else $error("cycle pulse too long");
   a_cycle_due: assert property (@(posedge clock) disable iff (srst)
      clk_en && !cycle_skip && cyc_cnt == 40'(PERIOD_CYC - 1) |=> cycle_start)
      else $error("cycle pulse missing");
   a_cycle_skip: assert property (@(posedge clock) disable iff (srst)
      clk_en && cycle_skip && cyc_cnt == 40'(PERIOD_CYC - 1) |=> !cycle_start)
      else $error("skipped cycle still pulsed");
endmodule
`default_nettype wire

/* File: test/hkgate_tc_source.sv */
`timescale 1ns/1ps
`default_nettype none
// Spacecraft telecommand source driving the decoder byte stream
module hkgate_tc_source
   import hkgate_pkg::*;
(
   // Clock
   input  wire logic  clock,
   // Byte stream
   output logic       tc_valid,
   output logic [7:0] tc_data,
   output logic       tc_last
);
   // One identifier/category pair in use, so one counter
   logic [10:0] seq_cnt = 11'h000;
   initial begin
      tc_valid = 1'b0;
      tc_data  = 8'h00;
      tc_last  = 1'b0;
   end
   // Build a packet; byte idx is flipped by mask, n bytes go out
   // Beyond 14 bytes the packet repeats from its start as a tail
   task automatic send(input logic [7:0] sub, input int idx, input logic [7:0] mask,
                       input int n);
      logic [7:0]  b [0:13];
      logic [15:0] ck;
      b[0] = {VERSION_NUMBER, TYPE_TC, DFH_FLAG, APID_VALUE[6:4]};
      b[1] = {APID_VALUE[3:0], CATEGORY_VALUE};
      b[2] = {SEQ_FLAGS_VALUE, SEQ_SOURCE_GND, seq_cnt[10:8]};
      b[3] = seq_cnt[7:0];
      {b[4], b[5]} = LENGTH_VALUE;
      b[6] = {SEC_VERSION, CKSUM_FLAG, ACK_VALUE};
      b[7] = SERVICE_HK;
      b[8] = sub;
      b[9] = PAD_HEADER;
      b[10] = PAD_PARAM_VALUE;
      b[11] = SELECTOR_VALUE;
      // Header faults go in before the sum, so only the field is wrong
      if (idx < 12)
         b[idx] = b[idx] ^ mask;
      ck = 16'h0000;
      for (int i = 0; i < 12; i += 2)
         ck = ck ^ {b[i], b[i+1]};
      {b[12], b[13]} = ck;
      if (idx >= 12 && idx < 14)
         b[idx] = b[idx] ^ mask;
      seq_cnt = seq_cnt + 11'h001;
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         tc_valid <= 1'b1;
         tc_data  <= b[i % 14];
         tc_last  <= (i == n - 1);
      end
      @(posedge clock);
      tc_valid <= 1'b0;
      tc_last  <= 1'b0;
      tc_data  <= ~tc_data; // Released line must not show the stale byte
   endtask
endmodule
`default_nettype wire

/* File: test/housekeeping_report_gate_tc_decoder_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the housekeeping forwarding gate
module housekeeping_report_gate_tc_decoder_bench
   import hkgate_pkg::*;
;
   typedef struct packed {
      logic [7:0] sub;
      logic [3:0] idx;
      logic [7:0] mask;
      logic [4:0] n;
      logic       acc;
      logic       fwd;
   } hkgate_row_type;
   logic       clock, srst, clk_en, cycle_skip, hk_done; // Driven inputs
   logic       tc_valid, tc_last, tc_ready;              // Byte stream
   logic [7:0] tc_data;                                  // Byte value
   logic       cycle_start, hk_forward, hk_discard;      // Gate outputs
   logic       fwd_enabled, cmd_accepted, cmd_rejected;  // Command outputs
   int         num_errors, checks_done, starts, s0;      // Bench counters
   // Command, fault byte, flip mask, length, accepted, forwarding after
   hkgate_row_type rows [0:13] = '{
      '{SUBTYPE_ENABLE, 4'hf, 8'h00, 5'he, 1'b1, 1'b1},
      '{SUBTYPE_ENABLE, 4'hf, 8'h00, 5'he, 1'b1, 1'b1},
      '{SUBTYPE_ENABLE, 4'hc, 8'h01, 5'he, 1'b0, 1'b1},
      '{SUBTYPE_DISABLE, 4'h1, 8'h10, 5'he, 1'b0, 1'b1},
      '{8'h07, 4'hf, 8'h00, 5'he, 1'b0, 1'b1},
      '{SUBTYPE_DISABLE, 4'hf, 8'h00, 5'he, 1'b1, 1'b0},
      '{SUBTYPE_ENABLE, 4'hf, 8'h00, 5'hd, 1'b0, 1'b0},
      '{SUBTYPE_ENABLE, 4'h5, 8'h01, 5'he, 1'b0, 1'b0},
      '{SUBTYPE_ENABLE, 4'h6, 8'h02, 5'he, 1'b0, 1'b0},
      '{SUBTYPE_ENABLE, 4'h7, 8'hc3, 5'he, 1'b0, 1'b0},
      '{SUBTYPE_ENABLE, 4'hb, 8'h03, 5'he, 1'b0, 1'b0},
      '{SUBTYPE_ENABLE, 4'hf, 8'h00, 5'he, 1'b1, 1'b1},
      '{SUBTYPE_DISABLE, 4'hd, 8'h80, 5'he, 1'b0, 1'b1},
      '{SUBTYPE_DISABLE, 4'hf, 8'h00, 5'he, 1'b1, 1'b0}};
   hkgate_tc_source src (.clock(clock), .tc_valid(tc_valid), .tc_data(tc_data),
                         .tc_last(tc_last));
   // Short period keeps the cycle checks brief
   hkgate_top #(.PERIOD_CYC(20)) DUT (.clock(clock), .srst(srst), .clk_en(clk_en),
      .tc_valid(tc_valid), .tc_data(tc_data), .tc_last(tc_last), .tc_ready(tc_ready),
      .cycle_skip(cycle_skip), .hk_done(hk_done), .cycle_start(cycle_start),
      .hk_forward(hk_forward), .hk_discard(hk_discard), .fwd_enabled(fwd_enabled),
      .cmd_accepted(cmd_accepted), .cmd_rejected(cmd_rejected));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Collection cycle pulses seen so far
   always @(posedge clock)
      if (cycle_start === 1'b1)
         starts <= starts + 1;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask
   // One packet completion, judged one cycle later
   task pulse_done(input logic exp);
      @(posedge clock);
      hk_done <= 1'b1;
      @(posedge clock);
      hk_done <= 1'b0;
      #1;
      check(hk_forward, exp);
      check(hk_discard, !exp);
   endtask
   // Count cycle pulses over five periods
   task count_cycles(input logic [31:0] exp);
      repeat (2) @(posedge clock);
      s0 = starts;
      repeat (100) @(posedge clock);
      check(starts - s0, exp);
   endtask
   task stop_test();
      $display("Errors %0d, checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Watchdog far beyond the expected run
   initial begin
      #(25 * 5000);
      num_errors++;
      stop_test();
   end
   initial begin
      {srst, clk_en, cycle_skip, hk_done, starts, num_errors, checks_done} = {4'hc, 96'h0};
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      #1;
      check(fwd_enabled, 1'b0);
      pulse_done(1'b0);
      foreach (rows[i]) begin
         src.send(rows[i].sub, rows[i].idx, rows[i].mask, rows[i].n);
         #1;
         check(cmd_accepted, rows[i].acc);
         check(cmd_rejected, !rows[i].acc);
         check(fwd_enabled, rows[i].fwd);
         pulse_done(rows[i].fwd);
      end
      count_cycles(32'h5);
      // Overlong packet: judged on its first 14 bytes, tail skipped quietly
      src.send(SUBTYPE_ENABLE, 15, 8'h00, 16);
      #1;
      check(cmd_rejected, 1'b0);
      check(fwd_enabled, 1'b1);
      check(tc_ready, 1'b1);
      count_cycles(32'h5);
      cycle_skip <= 1'b1;
      count_cycles(32'h0);
      cycle_skip <= 1'b0;
      // Frozen clock enable: a completion must not leak through
      clk_en <= 1'b0;
      @(posedge clock);
      hk_done <= 1'b1;
      @(posedge clock);
      hk_done <= 1'b0;
      #1;
      check(hk_forward, 1'b0);
      check(hk_discard, 1'b0);
      // Reset in mid-run drops forwarding again
      @(posedge clock);
      clk_en <= 1'b1;
      srst   <= 1'b1;
      @(posedge clock);
      srst <= 1'b0;
      #1;
      check(fwd_enabled, 1'b0);
      // First command after the mid-run reset
      src.send(SUBTYPE_ENABLE, 15, 8'h00, 14);
      #1;
      check(cmd_accepted, 1'b1);
      check(fwd_enabled, 1'b1);
      stop_test();
   end
endmodule
`default_nettype wire
